// File: smtc_consts.vh
// Constants for the synchronous modem transmit and command controller.
`ifndef SMTC_CONSTS_VH
`define SMTC_CONSTS_VH

// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define SMTC_ADDR_CMD      4'h0
`define SMTC_ADDR_STATUS   4'h4
`define SMTC_ADDR_EVENT    4'h8
`define SMTC_ADDR_OUTDATA  4'hc

// ----------------------------------------------------------------------
// Command word bit positions
// ----------------------------------------------------------------------
`define SMTC_CB_CONNECT    1
`define SMTC_CB_IN_SEL     2
`define SMTC_CB_OUT_SEL    3
`define SMTC_CB_RTS_ON     4
`define SMTC_CB_RTS_OFF    5
`define SMTC_CB_SYNC       6
`define SMTC_CB_DTR_ON     7
`define SMTC_CB_DTR_OFF    8
`define SMTC_CB_CALL       9
`define SMTC_CB_MODE_STB   10
`define SMTC_CB_PARITY     11
`define SMTC_CB_CHAR       12
`define SMTC_CB_ROUTE      13
`define SMTC_CB_CALL_STB   15

// ----------------------------------------------------------------------
// Event register bit positions (write one to pulse)
// ----------------------------------------------------------------------
`define SMTC_EB_FIRST      0
`define SMTC_EB_SECOND     1
`define SMTC_EB_MISS       2
`define SMTC_EB_LOAD       3
`define SMTC_EB_GATE_IN    4
`define SMTC_EB_PAR_CLR    5

// ----------------------------------------------------------------------
// Timing counts and command reset word
// ----------------------------------------------------------------------
`define SMTC_BIT_COUNT     8
`define SMTC_SLOW_COUNT    16
`define SMTC_ONESHOT_CYC   4
`define SMTC_CMD_RESET     16'h0000

`endif

// File: smtc_ctrl.v
// Synchronous modem interface control: sync completion, transmit timing, command register.
`timescale 1ns/10ps
`include "smtc_consts.vh"

module smtc_ctrl #(
    parameter BITS = `SMTC_BIT_COUNT
) (
    input  wire        clk,
    input  wire        rst_n,
    input  wire [3:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    input  wire        modem_tx_clock,
    input  wire        transmit_enable,
    output reg         input_load_enable,
    output reg         parity_count_pulse,
    output wire        input_interrupt,
    output wire        output_interrupt,
    output wire        in_sync_interrupt,
    output reg         output_load_pulse,
    output reg         parity_char_load,
    output reg         serial_shift_pulse,
    output wire        output_ready_to_modem,
    output wire        transmit_data_ready,
    output reg         dataset_reg_strobe,
    output reg         autodial_reg_strobe,
    output wire        request_to_send,
    output wire        data_terminal_ready,
    output wire        call_request
);

    // Constants kept at full width and cut on use, so no bit is lost silently.
    localparam        BW       = $clog2(BITS);
    localparam [31:0] BIT_LAST = BITS - 1;
    localparam [31:0] SHOT_LEN = `SMTC_ONESHOT_CYC;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    reg         ack_q;
    wire        req = (avs_read | avs_write) & ~ack_q;
    wire        wr  = avs_write & ~ack_q;
    wire        rd  = avs_read & ~ack_q;
    reg         command_strobe;
    reg         output_reg_strobe;
    reg         ev_wr;
    wire [15:0] cw = avs_writedata[15:0];

    // One wait state per access, so every request answers on its second edge.
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

    always @* begin
        command_strobe    = 1'b0;
        output_reg_strobe = 1'b0;
        ev_wr             = 1'b0;
        if (wr && avs_address == `SMTC_ADDR_CMD) begin
            command_strobe = 1'b1;
        end else if (wr && avs_address == `SMTC_ADDR_OUTDATA) begin
            output_reg_strobe = 1'b1;
        end else if (wr && avs_address == `SMTC_ADDR_EVENT) begin
            ev_wr = 1'b1;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            ack_q <= 1'b0;
        end else begin
            ack_q <= req;
        end
    end

    // Software-driven receive events, one-cycle pulses.
    wire first_word_match_strobe  = ev_wr & cw[`SMTC_EB_FIRST];
    wire second_word_match_strobe = ev_wr & cw[`SMTC_EB_SECOND];
    wire second_miss              = ev_wr & cw[`SMTC_EB_MISS];
    wire input_reg_load           = ev_wr & cw[`SMTC_EB_LOAD];
    wire gate_input_to_bus        = ev_wr & cw[`SMTC_EB_GATE_IN];
    wire receive_parity_clear     = ev_wr & cw[`SMTC_EB_PAR_CLR];
    wire begin_sync_cmd           = command_strobe & cw[`SMTC_CB_SYNC];

    // ------------------------------------------------------------------
    // Receive sync completion
    // ------------------------------------------------------------------
    reg sync_mode_q;
    reg first_found_q;
    reg in_sync_q;
    reg input_ready_q;
    reg in_ie_q;
    reg out_ie_q;
    reg [2:0] shot_q;

    always @(posedge clk) begin
        if (!rst_n) begin
            sync_mode_q   <= 1'b0;
            first_found_q <= 1'b0;
            in_sync_q     <= 1'b0;
        end else if (begin_sync_cmd) begin
            sync_mode_q   <= 1'b1;
            first_found_q <= 1'b0;
            in_sync_q     <= 1'b0;
        end else if (second_word_match_strobe && first_found_q) begin
            in_sync_q     <= 1'b1;
            sync_mode_q   <= 1'b0;
            first_found_q <= 1'b0;
        end else if (second_miss) begin
            first_found_q <= 1'b0;
        end else if (first_word_match_strobe && sync_mode_q) begin
            first_found_q <= 1'b1;
        end
    end

    // Load enable pulse and parity count pulse.
    always @(posedge clk) begin
        if (!rst_n) begin
            input_load_enable  <= 1'b0;
            parity_count_pulse <= 1'b0;
        end else begin
            input_load_enable  <= second_word_match_strobe & first_found_q;
            parity_count_pulse <= first_word_match_strobe | second_word_match_strobe
                                  | input_reg_load;
        end
    end

    // Input ready: load sets, and set wins over a clear in the same cycle.
    always @(posedge clk) begin
        if (!rst_n) begin
            input_ready_q <= 1'b0;
        end else if (input_reg_load) begin
            input_ready_q <= 1'b1;
        end else if (gate_input_to_bus | receive_parity_clear | begin_sync_cmd) begin
            input_ready_q <= 1'b0;
        end
    end

    assign input_interrupt = input_ready_q & in_ie_q;

    // One-shot fired by every second_word_match_strobe, in sync or not, stretched over a few cycles so slow logic sees it.
    always @(posedge clk) begin
        if (!rst_n) begin
            shot_q <= 3'h0;
        end else if (second_word_match_strobe) begin
            shot_q <= SHOT_LEN[2:0];
        end else if (shot_q != 3'h0) begin
            shot_q <= shot_q - 3'h1;
        end
    end

    assign in_sync_interrupt = (shot_q != 3'h0);

    // ------------------------------------------------------------------
    // Command register
    // ------------------------------------------------------------------
    reg parity_enable;
    reg char_mode_high;
    reg route_autodial_q;
    reg rts_q;
    reg dtr_q;
    reg call_q;

    // Only fields addressed by a strobe change; all others hold.
    always @(posedge clk) begin
        if (!rst_n) begin
            parity_enable    <= 1'b0;
            char_mode_high   <= 1'b0;
            route_autodial_q <= 1'b0;
            rts_q            <= 1'b0;
            dtr_q            <= 1'b0;
            in_ie_q          <= 1'b0;
            out_ie_q         <= 1'b0;
        end else if (command_strobe) begin
            if (cw[`SMTC_CB_MODE_STB]) begin
                parity_enable    <= cw[`SMTC_CB_PARITY];
                char_mode_high   <= cw[`SMTC_CB_CHAR];
                route_autodial_q <= cw[`SMTC_CB_ROUTE];
            end
            if (cw[`SMTC_CB_RTS_ON]) begin
                rts_q <= 1'b1;
            end else if (cw[`SMTC_CB_RTS_OFF]) begin
                rts_q <= 1'b0;
            end
            if (cw[`SMTC_CB_DTR_ON]) begin
                dtr_q <= 1'b1;
            end else if (cw[`SMTC_CB_DTR_OFF]) begin
                dtr_q <= 1'b0;
            end
            if (cw[`SMTC_CB_IN_SEL]) begin
                in_ie_q <= cw[`SMTC_CB_CONNECT];
            end
            if (cw[`SMTC_CB_OUT_SEL]) begin
                out_ie_q <= cw[`SMTC_CB_CONNECT];
            end
        end
    end

    // Call request is dropped whenever terminal ready is low.
    always @(posedge clk) begin
        if (!rst_n || !dtr_q) begin
            call_q <= 1'b0;
        end else if (command_strobe && cw[`SMTC_CB_CALL_STB]) begin
            call_q <= cw[`SMTC_CB_CALL];
        end
    end

    // Output strobes routed to one register bank, registered one cycle.
    always @(posedge clk) begin
        if (!rst_n) begin
            dataset_reg_strobe  <= 1'b0;
            autodial_reg_strobe <= 1'b0;
        end else begin
            dataset_reg_strobe  <= output_reg_strobe & ~route_autodial_q;
            autodial_reg_strobe <= output_reg_strobe & route_autodial_q;
        end
    end

    assign request_to_send     = rts_q;
    assign data_terminal_ready = dtr_q;
    assign call_request        = call_q;

    // ------------------------------------------------------------------
    // Transmit timing on the modem clock
    // ------------------------------------------------------------------
    wire txc_s;
    reg  txc_prev_q;
    reg  [BW-1:0] bit_cnt_q;
    reg  [3:0]    slow_cnt_q;
    reg  busy_q;
    reg  load_armed_q;
    reg  parity_pend_q;
    reg  parity_sent_q;
    wire tick;
    wire timing_phase_one;
    wire timing_phase_two;

    smtc_sync u_txc_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .d     (modem_tx_clock),
        .q     (txc_s)
    );

    // Rising modem clock edges are the only bit-timing events.
    assign tick = txc_s & ~txc_prev_q;
    assign timing_phase_one = tick & (bit_cnt_q == {BW{1'b0}});
    assign timing_phase_two = tick & (bit_cnt_q == BIT_LAST[BW-1:0]);

    // Counters; character mode keeps the sixteen count initialised.
    always @(posedge clk) begin
        if (!rst_n) begin
            txc_prev_q <= 1'b0;
            bit_cnt_q  <= {BW{1'b0}};
            slow_cnt_q <= 4'h0;
        end else begin
            txc_prev_q <= txc_s;
            if (tick) begin
                bit_cnt_q <= (bit_cnt_q == BIT_LAST[BW-1:0]) ? {BW{1'b0}}
                             : bit_cnt_q + {{(BW-1){1'b0}}, 1'b1};
                if (char_mode_high) begin
                    slow_cnt_q <= 4'h0;
                end else if (bit_cnt_q == BIT_LAST[BW-1:0]) begin
                    slow_cnt_q <= slow_cnt_q + 4'h1;
                end
            end
        end
    end

    // Busy and load arming; a write wins over the clearing load pulse.
    always @(posedge clk) begin
        if (!rst_n) begin
            busy_q       <= 1'b0;
            load_armed_q <= 1'b0;
        end else begin
            if (output_reg_strobe) begin
                busy_q <= 1'b1;
            end else if (output_load_pulse && char_mode_high) begin
                busy_q <= 1'b0;
            end
            if (timing_phase_one && busy_q) begin
                load_armed_q <= 1'b1;
            end else if (timing_phase_two && !busy_q) begin
                load_armed_q <= 1'b0;
            end
        end
    end

    // Parity pending rises with enabled parity, held clear otherwise.
    always @(posedge clk) begin
        if (!rst_n || !parity_enable) begin
            parity_pend_q <= 1'b0;
            parity_sent_q <= 1'b0;
        end else if (output_load_pulse) begin
            parity_pend_q <= 1'b1;
            parity_sent_q <= 1'b0;
        end else if (parity_char_load) begin
            parity_pend_q <= 1'b0;
            parity_sent_q <= 1'b1;
        end
    end

    // Load pulses only at counter zero, so a byte never gets cut short.
    always @(posedge clk) begin
        if (!rst_n) begin
            output_load_pulse  <= 1'b0;
            parity_char_load   <= 1'b0;
            serial_shift_pulse <= 1'b0;
        end else begin
            output_load_pulse  <= timing_phase_one & load_armed_q & busy_q
                                  & transmit_enable;
            parity_char_load   <= timing_phase_one & ~load_armed_q & parity_pend_q
                                  & transmit_enable;
            serial_shift_pulse <= tick;
        end
    end

    // Ready to modem only with parity enabled, once no load is armed and no parity is pending.
    assign output_ready_to_modem = parity_enable & ~load_armed_q & ~parity_pend_q;
    assign transmit_data_ready   = busy_q;
    assign output_interrupt      = out_ie_q & ~busy_q;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (rd && avs_address == `SMTC_ADDR_STATUS) begin
            avs_readdata <= {16'h0000, slow_cnt_q, parity_sent_q, parity_pend_q,
                             load_armed_q, busy_q, call_q, dtr_q, rts_q,
                             char_mode_high, parity_enable, in_sync_q,
                             input_ready_q, sync_mode_q};
        end else if (rd && avs_address == `SMTC_ADDR_CMD) begin
            avs_readdata <= {26'h0000000, out_ie_q, in_ie_q, route_autodial_q,
                             first_found_q, bit_cnt_q == {BW{1'b0}}, 1'b0};
        end else if (rd) begin
            avs_readdata <= 32'h00000000;
        end
    end
endmodule // smtc_ctrl

// File: smtc_ctrl_asserts.sv
// Concurrent checks on the ports of the modem transmit and command controller.
`timescale 1ns/10ps

module smtc_ctrl_asserts #(
    parameter BITS = 8
) (
    input wire        clk,
    input wire        rst_n,
    input wire [3:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire        avs_waitrequest,
    input wire        transmit_enable,
    input wire        output_load_pulse,
    input wire        parity_count_pulse,
    input wire        input_interrupt,
    input wire        output_interrupt,
    input wire        transmit_data_ready,
    input wire        dataset_reg_strobe,
    input wire        autodial_reg_strobe,
    input wire        request_to_send,
    input wire        data_terminal_ready,
    input wire        call_request
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // ------------------------------------------------------------------
    // Request decode
    // ------------------------------------------------------------------
    // Side effects land on the first edge of a request, so decode it there.
    wire cmd_w = avs_write && avs_waitrequest && (avs_address == 4'h0);
    wire evt_w = avs_write && avs_waitrequest && (avs_address == 4'h8);
    wire out_w = avs_write && avs_waitrequest && (avs_address == 4'hc);

    a_wait_once: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("waitrequest held longer than one cycle");
    a_rts_on: assert property (cmd_w && avs_writedata[4] |=> request_to_send)
        else $error("request to send not raised");
    a_rts_off: assert property (cmd_w && avs_writedata[5:4] == 2'b10 |=> !request_to_send)
        else $error("request to send not dropped");
    a_dtr_on: assert property (cmd_w && avs_writedata[7] |=> data_terminal_ready)
        else $error("terminal ready not raised");
    a_dtr_off: assert property (cmd_w && avs_writedata[8:7] == 2'b10 |=> !data_terminal_ready)
        else $error("terminal ready not dropped");
    a_call_load: assert property (cmd_w && avs_writedata[15] && data_terminal_ready
        && !avs_writedata[8] |=> call_request == $past(avs_writedata[9]))
        else $error("call request not loaded from bit 9");
    a_call_clear: assert property (!data_terminal_ready && !$past(data_terminal_ready)
        |-> !call_request)
        else $error("call request set while terminal ready low");
    a_cmd_hold: assert property (!cmd_w |=> $stable(request_to_send)
        && $stable(data_terminal_ready))
        else $error("modem control changed without a command");
    a_busy_set: assert property (out_w && !output_load_pulse |=> transmit_data_ready)
        else $error("busy not set by output write");
    a_busy_drop: assert property ($fell(transmit_data_ready) |-> $past(output_load_pulse))
        else $error("busy dropped without a load pulse");
    a_load_gap: assert property (output_load_pulse |=> !output_load_pulse [*8])
        else $error("load pulses closer than a character");
    a_load_gate: assert property (output_load_pulse |-> $past(transmit_enable))
        else $error("load pulse while transmit disabled");
    a_out_int: assert property (output_interrupt |-> !transmit_data_ready)
        else $error("output interrupt while busy");
    a_par_count: assert property (evt_w && (avs_writedata[0] || avs_writedata[3])
        |-> ##[1:2] parity_count_pulse)
        else $error("no parity count pulse");
    a_in_clear: assert property (evt_w && avs_writedata[4:3] == 2'b10 |=> !input_interrupt)
        else $error("input ready not cleared by read");
    a_route_one: assert property (out_w |=> dataset_reg_strobe != autodial_reg_strobe)
        else $error("output strobe not routed to one target");
endmodule // smtc_ctrl_asserts

bind smtc_ctrl smtc_ctrl_asserts #(.BITS(BITS)) smtc_ctrl_asserts_i (.clk, .rst_n, .avs_address,
    .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .transmit_enable, .output_load_pulse,
    .parity_count_pulse, .input_interrupt, .output_interrupt, .transmit_data_ready,
    .dataset_reg_strobe, .autodial_reg_strobe, .request_to_send, .data_terminal_ready,
    .call_request);

// File: smtc_modem_model.sv
// Behavioural modem: free-running transmit timing and bit times counted per load.
`timescale 1ns/10ps

module smtc_modem_model #(
    parameter HALF_NS = 200
) (
    input  wire       clk,
    input  wire       output_load_pulse,
    output reg        modem_tx_clock = 1'b0,
    output reg  [7:0] gap_bits = 8'h00
);
    reg       mc_q    = 1'b0;
    reg [7:0] edges_q = 8'h00;

    // The modem clock never stops; the odd offset keeps it out of phase with clk.
    initial begin
        #7;
        forever #(HALF_NS) modem_tx_clock = ~modem_tx_clock;
    end

    // Rising modem edges since the last load, latched at each load for the bench.
    always @(posedge clk) begin
        mc_q <= modem_tx_clock;
        if (output_load_pulse) begin
            gap_bits <= edges_q;
            edges_q  <= {7'h00, modem_tx_clock & ~mc_q};
        end else begin
            edges_q <= edges_q + {7'h00, modem_tx_clock & ~mc_q};
        end
    end
endmodule // smtc_modem_model

// File: smtc_sync.v
// Two flip-flop synchroniser for a single level.
`timescale 1ns/10ps

module smtc_sync (
    clk,
    rst_n,
    d,
    q
);
    input  wire clk;
    input  wire rst_n;
    input  wire d;
    output wire q;

    reg meta_q;
    reg sync_q;

    // ------------------------------------------------------------------
    // First stage feeds only the second stage.
    // ------------------------------------------------------------------
    always @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;
endmodule // smtc_sync

// File: test_smtc_ctrl.sv
// Self-checking bench for the modem transmit and command controller.
`timescale 1ns/10ps

module test_smtc_ctrl;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    reg  [3:0]  avs_address = 4'h0;
    reg         avs_read = 1'b0;
    reg         avs_write = 1'b0;
    reg  [31:0] avs_writedata = 32'h0;
    reg         transmit_enable = 1'b0;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest, modem_tx_clock, input_load_enable, parity_count_pulse;
    wire        input_interrupt, output_interrupt, in_sync_interrupt, output_load_pulse;
    wire        parity_char_load, serial_shift_pulse, transmit_data_ready, output_ready_to_modem;
    wire        request_to_send, data_terminal_ready, call_request;
    wire [7:0]  gap_bits;
    integer     n_mismatch = 0, num_checks = 0, n_load = 0, n_par = 0, i, k;
    integer     n_sft = 0, sft_gap = 0;
    reg  [31:0] rd, cw;
    reg         rts, dtr, call, par, chr, route, in_ie, out_ie;
    reg         saw_sync = 1'b0, saw_input_load_enable = 1'b0;

    smtc_ctrl smtc_ctrl_i (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .modem_tx_clock(modem_tx_clock), .transmit_enable(transmit_enable),
        .input_load_enable(input_load_enable), .parity_count_pulse(parity_count_pulse),
        .input_interrupt(input_interrupt), .output_interrupt(output_interrupt),
        .in_sync_interrupt(in_sync_interrupt), .output_load_pulse(output_load_pulse),
        .parity_char_load(parity_char_load), .serial_shift_pulse(serial_shift_pulse),
        .output_ready_to_modem(output_ready_to_modem),
        .transmit_data_ready(transmit_data_ready),
        .dataset_reg_strobe(), .autodial_reg_strobe(), .request_to_send(request_to_send),
        .data_terminal_ready(data_terminal_ready), .call_request(call_request));
    smtc_modem_model smtc_modem_model_i (.clk(clk), .output_load_pulse(output_load_pulse),
        .modem_tx_clock(modem_tx_clock), .gap_bits(gap_bits));

    always #12.5 clk = ~clk;

    // ------------------------------------------------------------------
    // Event tallies
    // ------------------------------------------------------------------
    // Pulses are one cycle wide, so they are counted on every edge.
    always @(posedge clk) begin
        if (output_load_pulse === 1'b1) n_load = n_load + 1;
        if (parity_char_load === 1'b1) n_par = n_par + 1;
        if (in_sync_interrupt === 1'b1) saw_sync = 1'b1;
        if (input_load_enable === 1'b1) saw_input_load_enable = 1'b1;
        // Shift pulses between two loads, the load's own cycle counted first.
        if (output_load_pulse === 1'b1) begin
            sft_gap = n_sft;
            n_sft = 0;
        end
        if (serial_shift_pulse === 1'b1) n_sft = n_sft + 1;
    end

    task chk(input [31:0] got, input [31:0] exp);
        begin
            num_checks = num_checks + 1;
            if (got !== exp) begin
                n_mismatch = n_mismatch + 1;
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    // One bus transfer; holds everything until waitrequest is seen low at an edge.
    task bus(input wr, input [3:0] a, input [31:0] d);
        integer t;
        begin
            t = 0;
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= wr;
            avs_read <= ~wr;
            do begin
                @(posedge clk);
                t = t + 1;
            end while (avs_waitrequest !== 1'b0 && t < 50);
            if (avs_waitrequest !== 1'b0) n_mismatch = n_mismatch + 1;
            rd = avs_readdata;
            avs_write <= 1'b0;
            avs_read <= 1'b0;
            @(posedge clk);
        end
    endtask

    // Waits for the load count to reach a value, with a bound against hangs.
    task wait_loads(input integer n);
        begin
            k = 0;
            while (n_load < n && k < 2000) begin @(posedge clk); k = k + 1; end
            if (n_load < n) n_mismatch = n_mismatch + 1;
            // One more edge so values latched with the load have settled.
            @(posedge clk);
        end
    endtask

    task final_report;
        begin
            if (n_mismatch == 0 && num_checks > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask

    initial begin
        #(25 * 20000);
        n_mismatch = n_mismatch + 1;
        final_report;
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        k = $urandom(32'h513f);
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        bus(0, 4'h4, 32'h0);
        chk(rd & 32'h0fff, 32'h0);
        bus(0, 4'h2, 32'h0);
        chk(rd, 32'h0);
        {rts, dtr, call, par, chr, route, in_ie, out_ie} = 8'h00;
        // Random command words, the first three forced to the awkward cases.
        for (i = 0; i < 24; i = i + 1) begin
            cw = (i == 0) ? 32'h00b0 : (i == 1) ? 32'h82a0 : (i == 2) ? 32'h0100
                 : ($urandom & 32'hbfbe);
            if (!dtr && cw[7]) cw[15] = 1'b0;
            bus(1, 4'h0, cw);
            rts = cw[4] | (rts & ~cw[5]);
            dtr = cw[7] | (dtr & ~cw[8]);
            call = dtr & (cw[15] ? cw[9] : call);
            if (cw[10]) {par, chr, route} = {cw[11], cw[12], cw[13]};
            if (cw[2]) in_ie = cw[1];
            if (cw[3]) out_ie = cw[1];
            chk({request_to_send, data_terminal_ready, call_request}, {rts, dtr, call});
            bus(0, 4'h4, 32'h0);
            chk(rd & 32'hf8, {call, dtr, rts, chr, par, 3'b000});
            bus(0, 4'h0, 32'h0);
            chk(rd & 32'h38, {out_ie, in_ie, route, 3'b000});
        end
        // Input ready set by a load, cleared by read, parity clear and begin-sync.
        bus(1, 4'h0, 32'h0006);
        for (i = 0; i < 3; i = i + 1) begin
            bus(1, 4'h8, 32'h0008);
            chk(input_interrupt, 1'b1);
            if (i == 2) bus(1, 4'h0, 32'h0040);
            else bus(1, 4'h8, i ? 32'h0020 : 32'h0010);
            chk(input_interrupt, 1'b0);
        end
        bus(1, 4'h8, 32'h0001);
        bus(1, 4'h8, 32'h0004);
        bus(1, 4'h8, 32'h0002);
        bus(0, 4'h4, 32'h0);
        chk(rd & 32'h5, 32'h1);
        bus(1, 4'h8, 32'h0001);
        bus(1, 4'h8, 32'h0002);
        repeat (6) @(posedge clk);
        bus(0, 4'h4, 32'h0);
        chk(rd & 32'h5, 32'h4);
        chk({saw_sync, saw_input_load_enable}, 2'b11);
        // Character mode, parity off, output interrupt on; first word waits for enable.
        bus(1, 4'h0, 32'h140a);
        bus(1, 4'hc, $urandom & 32'hffff);
        chk(transmit_data_ready, 1'b1);
        repeat (300) @(posedge clk);
        chk(n_load, 0);
        transmit_enable <= 1'b1;
        wait_loads(1);
        repeat (2) @(posedge clk);
        chk({transmit_data_ready, output_interrupt}, 2'b01);
        bus(1, 4'hc, $urandom & 32'hffff);
        wait_loads(2);
        chk(gap_bits, 8'h08);
        chk(sft_gap, 8);
        repeat (400) @(posedge clk);
        chk(n_load, 2);
        chk(n_par, 0);
        chk(output_ready_to_modem, 1'b0);
        bus(1, 4'h0, 32'h1c00);
        bus(1, 4'hc, $urandom & 32'hffff);
        wait_loads(3);
        k = 0;
        while (n_par == 0 && k < 1000) begin @(posedge clk); k = k + 1; end
        chk(n_par != 0, 1'b1);
        @(posedge clk);
        chk(output_ready_to_modem, 1'b1);
        final_report;
    end
endmodule // test_smtc_ctrl
